// ### core/supply_monitor_reset_ctrl.sv
module supply_monitor_reset_ctrl
  import supply_monitor_pkg::*;
#(
  parameter logic       HAS_WARN_CTRL  = 1'b1,
  parameter logic [19:0] POR_DELAY_LOW  = 20'(POR_DELAY_LOW_CYC),
  parameter logic [19:0] POR_DELAY_MID  = 20'(POR_DELAY_MID_CYC),
  parameter logic [19:0] POR_DELAY_HIGH = 20'(POR_DELAY_HIGH_CYC)
) (
  input  logic        clk,
  input  logic        rst,
  input  logic        battery_above_por_async,
  input  logic [1:0]  battery_level_async,
  input  logic        supply_above_trip_async,
  input  logic        supply_early_ok_async,
  input  logic        battery_early_ok_async,
  input  logic        sleep_mode,
  input  logic        other_reset_req,
  input  logic        flash_op_req,
  input  logic [7:0]  sfr_addr,
  input  logic [7:0]  sfr_wdata,
  input  logic        sfr_wr,
  input  logic        sfr_rd,
  output logic [7:0]  sfr_rdata,
  output logic        core_reset,
  output logic        reset_pin_out,
  output logic        reset_pin_oe_n,
  output logic [15:0] fetch_vector,
  output logic        fetch_restart,
  output logic        battery_monitor_on,
  output logic        flash_op_grant,
  output logic        supply_warn_irq,
  output logic        battery_warn_irq
);

  seq_state_e   state_reg;
  seq_state_e   state_next;
  logic [5:0]   sync_vec;
  logic         bat_por_s;
  logic [1:0]   bat_level_s;
  logic         above_trip_s;
  logic         sup_ok_s;
  logic         bat_ok_s;
  logic         sup_ok_d_reg;
  logic         bat_ok_d_reg;
  logic         supply_monitor_on_reg;
  logic         monitor_select_reg;
  logic         supply_warn_irq_en_reg;
  logic         battery_warn_irq_en_reg;
  logic         battery_monitor_disable_reg;
  logic         por_flag_reg;
  logic         soft_flag_reg;
  logic         flash_err_flag_reg;
  logic         bat_low;
  logic         pf_trip;
  logic         soft_req;
  logic         flash_err_req;
  logic         any_other_rst;
  logic         sup_irq_en_eff;
  logic         bat_irq_en_eff;
  logic         timer_load;
  logic         timer_done;
  logic [TIMER_W-1:0] timer_value;

  // Release delay for the present rail level; longer for higher rails.
  function automatic logic [TIMER_W-1:0] por_delay_for(input logic [1:0] level);
    if (level == BAT_LEVEL_LOW) begin
      por_delay_for = POR_DELAY_LOW;
    end else if (level == BAT_LEVEL_MID) begin
      por_delay_for = POR_DELAY_MID;
    end else begin
      por_delay_for = POR_DELAY_HIGH;
    end
  endfunction

  // Every analog comparator output crosses into the clock domain here.
  level_sync #(.W(6)) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({battery_above_por_async, battery_level_async, supply_above_trip_async,
                supply_early_ok_async, battery_early_ok_async}),
    .sync_out (sync_vec)
  );

  assign bat_por_s    = sync_vec[5];
  assign bat_level_s  = sync_vec[4:3];
  assign above_trip_s = sync_vec[2];
  assign sup_ok_s     = sync_vec[1];
  assign bat_ok_s     = sync_vec[0];

  // A disabled battery monitor cannot report a low rail.
  assign bat_low = !bat_por_s && !battery_monitor_disable_reg;
  // Sleep gates the trip path only; the enable and select bits stay untouched.
  assign pf_trip = supply_monitor_on_reg && monitor_select_reg && !sleep_mode && !above_trip_s;
  assign soft_req = sfr_wr && (sfr_addr == RESET_CAUSE_ADDR) && sfr_wdata[SOFT_RST_BIT];
  assign flash_err_req = flash_op_req && !supply_monitor_on_reg;
  assign any_other_rst = soft_req || flash_err_req || other_reset_req;
  // Variants without the enable bits behave as if they were fixed.
  assign sup_irq_en_eff = HAS_WARN_CTRL ? supply_warn_irq_en_reg : 1'b1;
  assign bat_irq_en_eff = HAS_WARN_CTRL ? battery_warn_irq_en_reg : 1'b0;

  // Sequencer next state; rail loss outranks the trip, which outranks other causes.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_POR_HOLD: begin
        if (bat_por_s) begin
          state_next = ST_POR_DELAY;
        end
      end
      ST_POR_DELAY: begin
        if (!bat_por_s) begin
          state_next = ST_POR_HOLD;
        end else if (timer_done) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (bat_low) begin
          state_next = ST_POR_HOLD;
        end else if (pf_trip) begin
          state_next = ST_PF_HOLD;
        end else if (any_other_rst && battery_monitor_disable_reg) begin
          state_next = ST_POR_DELAY;
        end else if (any_other_rst) begin
          state_next = ST_SYS_RST;
        end
      end
      ST_SYS_RST: begin
        if (!bat_por_s) begin
          state_next = ST_POR_HOLD;
        end else if (timer_done) begin
          state_next = ST_RUN;
        end
      end
      ST_PF_HOLD: begin
        if (!bat_por_s) begin
          state_next = ST_POR_HOLD;
        end else if (above_trip_s) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_POR_HOLD;
      end
    endcase
  end

  // The timer is loaded on entry to either timed state.
  assign timer_load  = (state_next != state_reg) &&
                       ((state_next == ST_POR_DELAY) || (state_next == ST_SYS_RST));
  assign timer_value = (state_next == ST_POR_DELAY) ? por_delay_for(bat_level_s) : SYS_RST_HOLD_CYC;

  release_timer u_timer (
    .clk        (clk),
    .rst        (rst),
    .load       (timer_load),
    .load_value (timer_value),
    .done       (timer_done)
  );

  // Sequencer state.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_POR_HOLD;
    end else begin
      state_reg <= state_next;
    end
  end

  // Monitor enable and select are forced on at power-on or power-fail release; otherwise only software writes in run change them.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      supply_monitor_on_reg <= MON_ON_RST;
      monitor_select_reg    <= 1'b1;
    end else if ((state_reg == ST_POR_DELAY || state_reg == ST_PF_HOLD) && state_next == ST_RUN) begin
      supply_monitor_on_reg <= 1'b1;
      monitor_select_reg    <= 1'b1;
    end else if (state_reg == ST_RUN && sfr_wr) begin
      if (sfr_addr == SUPPLY_MON_CTRL_ADDR) begin
        supply_monitor_on_reg <= sfr_wdata[MON_ON_BIT];
      end
      if (sfr_addr == RESET_CAUSE_ADDR) begin
        // Clearing the select bit here drops the trip path; software keeps it one.
        monitor_select_reg <= sfr_wdata[POR_FLAG_BIT];
      end
    end
  end

  // Interrupt enables are ordinary control bits, restored by every reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      supply_warn_irq_en_reg  <= SUP_IRQ_EN_RST;
      battery_warn_irq_en_reg <= BAT_IRQ_EN_RST;
    end else if (state_reg != ST_RUN) begin
      supply_warn_irq_en_reg  <= SUP_IRQ_EN_RST;
      battery_warn_irq_en_reg <= BAT_IRQ_EN_RST;
    end else if (sfr_wr && sfr_addr == SUPPLY_MON_CTRL_ADDR) begin
      supply_warn_irq_en_reg  <= sfr_wdata[SUP_IRQ_EN_BIT];
      battery_warn_irq_en_reg <= sfr_wdata[BAT_IRQ_EN_BIT];
    end
  end

  // Battery monitor disable; any reset brings the monitor back.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      battery_monitor_disable_reg <= 1'b0;
    end else if (state_reg != ST_RUN) begin
      battery_monitor_disable_reg <= 1'b0;
    end else if (sfr_wr && sfr_addr == POWER_UNIT_MODE_ADDR) begin
      battery_monitor_disable_reg <= sfr_wdata[BAT_MON_DIS_BIT];
    end
  end

  // Cause flags; a power-fail release reports itself as a power-on.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      por_flag_reg       <= 1'b1;
      soft_flag_reg      <= 1'b0;
      flash_err_flag_reg <= 1'b0;
    end else if ((state_reg == ST_POR_DELAY || state_reg == ST_PF_HOLD) && state_next == ST_RUN) begin
      por_flag_reg       <= 1'b1;
      soft_flag_reg      <= 1'b0;
      flash_err_flag_reg <= 1'b0;
    end else if (state_reg == ST_RUN && state_next == ST_SYS_RST) begin
      por_flag_reg       <= 1'b0;
      soft_flag_reg      <= soft_req;
      flash_err_flag_reg <= flash_err_req && !soft_req;
    end
  end

  // Early-warning interrupts fire on the falling edge of the synced status.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sup_ok_d_reg     <= 1'b1;
      bat_ok_d_reg     <= 1'b1;
      supply_warn_irq  <= 1'b0;
      battery_warn_irq <= 1'b0;
    end else begin
      sup_ok_d_reg     <= sup_ok_s;
      bat_ok_d_reg     <= bat_ok_s;
      supply_warn_irq  <= sup_ok_d_reg && !sup_ok_s && sup_irq_en_eff && state_reg == ST_RUN;
      battery_warn_irq <= bat_ok_d_reg && !bat_ok_s && bat_irq_en_eff && state_reg == ST_RUN;
    end
  end

  // Pin and core reset follow the state one cycle later, straight from flops.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_reset     <= 1'b1;
      reset_pin_out  <= 1'b0;
      reset_pin_oe_n <= 1'b0;
      fetch_vector   <= RESET_VECTOR;
      fetch_restart  <= 1'b0;
    end else begin
      core_reset     <= state_reg != ST_RUN;
      reset_pin_out  <= 1'b0;
      // Soft, flash and other resets leave the pin alone while the battery monitor is enabled.
      reset_pin_oe_n <= !(state_reg == ST_POR_HOLD || state_reg == ST_POR_DELAY || state_reg == ST_PF_HOLD);
      fetch_vector   <= RESET_VECTOR;
      fetch_restart  <= state_reg == ST_RUN && core_reset;
    end
  end

  // Flash operations pass only with the core monitor on.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flash_op_grant     <= 1'b0;
      battery_monitor_on <= 1'b1;
    end else begin
      flash_op_grant     <= flash_op_req && supply_monitor_on_reg && state_reg == ST_RUN;
      battery_monitor_on <= !battery_monitor_disable_reg;
    end
  end

  // Read port; data appears the cycle after the strobe, unmapped reads give zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        SUPPLY_MON_CTRL_ADDR: begin
          sfr_rdata <= {supply_monitor_on_reg, above_trip_s, sup_ok_s, bat_ok_s,
                        supply_warn_irq_en_reg, battery_warn_irq_en_reg, 2'b00};
        end
        RESET_CAUSE_ADDR: begin
          sfr_rdata <= {1'b0, flash_err_flag_reg, 1'b0, soft_flag_reg, 2'b00, por_flag_reg, 1'b0};
        end
        POWER_UNIT_MODE_ADDR: begin
          sfr_rdata <= {2'b00, battery_monitor_disable_reg, 5'h00};
        end
        default: begin
          sfr_rdata <= 8'h00;
        end
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_POR_PIN: assert property ((state_reg == ST_POR_HOLD) |=> (!reset_pin_oe_n && core_reset))
    else $error("Pin or core not held while rail is below power-on level.");
  AST_POR_DELAY_HOLD: assert property ((state_reg == ST_POR_DELAY && !timer_done) |=> state_reg != ST_RUN)
    else $error("Released before the power-on delay ended.");
  AST_POR_FLAG: assert property ((state_reg == ST_POR_DELAY && timer_done && bat_por_s) |=> por_flag_reg)
    else $error("Power-on flag not set at release.");
  AST_OTHER_CLR: assert property ((state_reg == ST_RUN && state_next == ST_SYS_RST) |=> !por_flag_reg)
    else $error("Power-on flag survived another reset.");
  AST_BATTERY_MONITOR_DISABLE: assert property ((state_reg == ST_RUN && !bat_low && !pf_trip && any_other_rst &&
                                battery_monitor_disable_reg) |=> (state_reg == ST_POR_DELAY) ##2 battery_monitor_on)
    else $error("Disabled battery monitor did not force a full power-on.");
  AST_PF_ENTER: assert property ((state_reg == ST_RUN && !bat_low && pf_trip) |=>
                                 (state_reg == ST_PF_HOLD) ##1 (!reset_pin_oe_n && core_reset))
    else $error("Supply trip did not hold core and pin.");
  AST_PF_RESTORE: assert property ((state_reg == ST_PF_HOLD && bat_por_s && above_trip_s) |=>
                                   (supply_monitor_on_reg && monitor_select_reg && por_flag_reg))
    else $error("Monitor not enabled and selected after power-fail.");
  AST_PF_NODELAY: assert property ((state_reg == ST_PF_HOLD && bat_por_s && above_trip_s) |=>
                                   (state_reg == ST_RUN) ##1 !core_reset)
    else $error("Power-fail release was delayed.");
  AST_SOFT_KEEP: assert property ((state_reg == ST_SYS_RST) |=>
                                  ($stable(supply_monitor_on_reg) && $stable(monitor_select_reg)))
    else $error("Non-power reset altered monitor enable or select.");
  AST_SLEEP: assert property ((state_reg == ST_RUN && sleep_mode && !bat_low && !any_other_rst) |=>
                              state_reg == ST_RUN)
    else $error("Power-fail reset taken during sleep.");
  AST_WARN_IRQ: assert property (($fell(sup_ok_s) && sup_irq_en_eff && state_reg == ST_RUN) |=>
                                 supply_warn_irq)
    else $error("Early-warning interrupt missed.");
  AST_FLASH_ERR: assert property ((state_reg == ST_RUN && !bat_low && !pf_trip && flash_op_req &&
                                   !supply_monitor_on_reg && !battery_monitor_disable_reg) |=>
                                  (state_reg == ST_SYS_RST && !flash_op_grant))
    else $error("Flash operation with monitor off did not reset.");

  COV_POR_RELEASE: cover property ((state_reg == ST_POR_DELAY) ##1 (state_reg == ST_RUN));
  COV_PF_CYCLE: cover property ((state_reg == ST_PF_HOLD) ##1 (state_reg == ST_RUN));
  COV_SOFT_RST: cover property ((state_reg == ST_RUN && soft_req) ##1 (state_reg == ST_SYS_RST));
  COV_WARN: cover property (supply_warn_irq);

endmodule

// ### include/supply_monitor_pkg.sv
package supply_monitor_pkg;

  // Clock rate and release timing, times in their own units.
  localparam int CLK_PERIOD_NS     = 20;
  localparam int POR_DELAY_LOW_US  = 3000;
  localparam int POR_DELAY_MID_US  = 7000;
  localparam int POR_DELAY_HIGH_US = 15000;
  localparam int POR_DELAY_LOW_CYC  = (POR_DELAY_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_DELAY_MID_CYC  = (POR_DELAY_MID_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_DELAY_HIGH_CYC = (POR_DELAY_HIGH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W            = 20;
  localparam logic [TIMER_W-1:0] SYS_RST_HOLD_CYC = 20'h00004;

  // Register addresses on the special-function bus.
  localparam logic [7:0] SUPPLY_MON_CTRL_ADDR = 8'hff;
  localparam logic [7:0] RESET_CAUSE_ADDR     = 8'hef;
  localparam logic [7:0] POWER_UNIT_MODE_ADDR = 8'hb3;

  // Supply monitor control field positions.
  localparam int MON_ON_BIT       = 7;
  localparam int TRIP_STAT_BIT    = 6;
  localparam int SUP_OK_BIT       = 5;
  localparam int BAT_OK_BIT       = 4;
  localparam int SUP_IRQ_EN_BIT   = 3;
  localparam int BAT_IRQ_EN_BIT   = 2;
  // Reset cause and power unit field positions.
  localparam int FLASH_ERR_BIT    = 6;
  localparam int SOFT_RST_BIT     = 4;
  localparam int POR_FLAG_BIT     = 1;
  localparam int BAT_MON_DIS_BIT  = 5;

  // Reset values.
  localparam logic MON_ON_RST      = 1'b1;
  localparam logic SUP_IRQ_EN_RST  = 1'b1;
  localparam logic BAT_IRQ_EN_RST  = 1'b0;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  // Battery level codes from the level comparator.
  localparam logic [1:0] BAT_LEVEL_LOW = 2'h0;
  localparam logic [1:0] BAT_LEVEL_MID = 2'h1;

  typedef enum logic [2:0] {
    ST_POR_HOLD  = 3'h0,
    ST_POR_DELAY = 3'h1,
    ST_RUN       = 3'h2,
    ST_SYS_RST   = 3'h3,
    ST_PF_HOLD   = 3'h4
  } seq_state_e;

endpackage

// ### core/level_sync.sv
module level_sync #(
  parameter int W = 1
) (
  input  logic         clk,
  input  logic         rst,
  input  logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  // Two stages; only the second stage is read by anything else.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// ### core/release_timer.sv
module release_timer
  import supply_monitor_pkg::*;
(
  input  logic               clk,
  input  logic               rst,
  input  logic               load,
  input  logic [TIMER_W-1:0] load_value,
  output logic               done
);

  logic [TIMER_W-1:0] count_reg;

  // Loading N makes done rise N cycles later.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
    end else if (load) begin
      count_reg <= load_value;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  assign done = (count_reg == '0);

endmodule

// ### test/supply_rail_model.sv
module supply_rail_model (
  input  wire logic       bat_up,
  input  wire logic [1:0] bat_lvl,
  input  wire logic       sup_ok,
  input  wire logic       sup_warn_ok,
  input  wire logic       bat_warn_ok,
  output wire logic       battery_above_por_async,
  output wire logic [1:0] battery_level_async,
  output wire logic       supply_above_trip_async,
  output wire logic       supply_early_ok_async,
  output wire logic       battery_early_ok_async
);
  timeunit 1ns;
  timeprecision 1ps;

  // Comparators settle a few ns after the rail moves, off any clock edge.
  // A dead battery drags the trip and early-warning comparators low as well.
  assign #7 battery_above_por_async = bat_up;
  assign #7 battery_level_async     = bat_lvl;
  assign #3 supply_above_trip_async = bat_up & sup_ok;
  assign #5 supply_early_ok_async   = bat_up & sup_warn_ok;
  assign #9 battery_early_ok_async  = bat_up & bat_warn_ok;
endmodule

// ### test/supply_monitor_reset_ctrl_tb_top.sv
module supply_monitor_reset_ctrl_tb_top;
  import supply_monitor_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [19:0] DLY [3] = '{20'h00014, 20'h0001e, 20'h00028};
  logic        clk, rst, bat_up, sup_ok, sup_warn_ok, bat_warn_ok, sleep_mode;
  logic        other_reset_req, flash_op_req, sfr_wr, sfr_rd;
  logic [1:0]  bat_lvl, rd_hist;
  logic [7:0]  sfr_addr, sfr_wdata;
  logic [7:0]  exp_q[$], mask_q[$];
  logic [31:0] r;
  int          fails, n_tests, seed, n, grants;
  wire logic       por_a, trip_a, sok_a, bok_a;
  wire logic [1:0] lvl_a;
  wire logic [7:0] sfr_rdata;
  wire logic [15:0] fetch_vector;
  wire logic       core_reset, reset_pin_out, reset_pin_oe_n, fetch_restart;
  wire logic       battery_monitor_on, flash_op_grant, supply_warn_irq, battery_warn_irq;

  supply_monitor_reset_ctrl #(.HAS_WARN_CTRL(1'b1), .POR_DELAY_LOW(DLY[0]), .POR_DELAY_MID(DLY[1]),
    .POR_DELAY_HIGH(DLY[2])) i_dut (.clk(clk), .rst(rst), .battery_above_por_async(por_a),
    .battery_level_async(lvl_a), .supply_above_trip_async(trip_a), .supply_early_ok_async(sok_a),
    .battery_early_ok_async(bok_a), .sleep_mode(sleep_mode), .other_reset_req(other_reset_req),
    .flash_op_req(flash_op_req), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .core_reset(core_reset), .reset_pin_out(reset_pin_out),
    .reset_pin_oe_n(reset_pin_oe_n), .fetch_vector(fetch_vector), .fetch_restart(fetch_restart),
    .battery_monitor_on(battery_monitor_on), .flash_op_grant(flash_op_grant),
    .supply_warn_irq(supply_warn_irq), .battery_warn_irq(battery_warn_irq));

  supply_rail_model i_rail (.bat_up(bat_up), .bat_lvl(bat_lvl), .sup_ok(sup_ok), .sup_warn_ok(sup_warn_ok),
    .bat_warn_ok(bat_warn_ok), .battery_above_por_async(por_a), .battery_level_async(lvl_a),
    .supply_above_trip_async(trip_a), .supply_early_ok_async(sok_a), .battery_early_ok_async(bok_a));

  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic finish_test();
    if (!fails && n_tests)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic sig(input int w);
    case (w)
      0: return core_reset;
      1: return supply_warn_irq;
      2: return battery_warn_irq;
      default: return flash_op_grant;
    endcase
  endfunction

  // Counts falling edges until a signal shows a level; gives up one past the bound.
  task automatic watch(input int w, input logic v, input int max, output int cnt);
    cnt = 0;
    while (sig(w) !== v && cnt <= max) begin
      @(negedge clk);
      cnt++;
    end
  endtask

  task automatic await(input int w, input logic v, input int max);
    int c;
    watch(w, v, max, c);
    if (c > max) begin
      fails++;
      finish_test();
    end
  endtask

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clk);
    sfr_wr    <= 1'b0;
  endtask

  // The expected byte is queued here and judged by the read monitor.
  task automatic sfr_read(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    exp_q.push_back(e);
    mask_q.push_back(m);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge clk);
    sfr_rd   <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic pulse(input int w);
    @(posedge clk);
    if (w == 0) other_reset_req <= 1'b1;
    else flash_op_req <= 1'b1;
    @(posedge clk);
    other_reset_req <= 1'b0;
    flash_op_req    <= 1'b0;
  endtask

  // Read data is judged two falling edges after the strobe, whichever edge registers it.
  always @(negedge clk) begin
    if (rd_hist[1] && exp_q.size() > 0) begin
      check(16'(sfr_rdata & mask_q[0]), 16'(exp_q[0]));
      void'(exp_q.pop_front());
      void'(mask_q.pop_front());
    end
    if (flash_op_grant === 1'b1) grants++;
    rd_hist <= {rd_hist[0], sfr_rd};
  end

  // A hung sequence must still reach the verdict.
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    finish_test();
  end

  initial begin
    seed = 41;
    {fails, n_tests} = '0;
    {rst, sup_ok, sup_warn_ok, bat_warn_ok} = 4'hf;
    {bat_up, sleep_mode, other_reset_req, flash_op_req, sfr_wr, sfr_rd} = 6'h00;
    {bat_lvl, sfr_addr, sfr_wdata} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // Power up at every rail level, with a battery brown-out before each.
    for (int lv = 0; lv < 3; lv++) begin
      @(posedge clk);
      bat_up <= 1'b0;
      await(0, 1'b1, 8);
      repeat (4) @(negedge clk);
      check(16'({core_reset, reset_pin_oe_n, reset_pin_out}), 16'h0004);
      @(posedge clk);
      bat_lvl <= lv[1:0];
      bat_up  <= 1'b1;
      watch(0, 1'b0, 100, n);
      check(16'(n >= DLY[lv] && n <= DLY[lv] + 8), 16'h0001);
      check(fetch_vector, RESET_VECTOR);
      check(16'(fetch_restart), 16'h0001);
    end
    sfr_read(SUPPLY_MON_CTRL_ADDR, 8'hf8, 8'hff);
    sfr_read(RESET_CAUSE_ADDR, 8'h02, 8'h02);
    r = $random(seed);
    sfr_read({1'b0, r[6:0]}, 8'h00, 8'hff);
    sfr_write(RESET_CAUSE_ADDR, 8'h12);
    await(0, 1'b1, 8);
    await(0, 1'b0, 16);
    sfr_read(RESET_CAUSE_ADDR, 8'h10, 8'h12);
    // Monitor switched off and deselected; a soft reset must leave that alone.
    sfr_write(SUPPLY_MON_CTRL_ADDR, 8'h08);
    sfr_write(RESET_CAUSE_ADDR, 8'h10);
    await(0, 1'b1, 8);
    await(0, 1'b0, 16);
    sfr_read(SUPPLY_MON_CTRL_ADDR, 8'h00, 8'h80);
    pulse(1);
    await(0, 1'b1, 8);
    await(0, 1'b0, 16);
    check(16'(grants), 16'h0000);
    sfr_read(RESET_CAUSE_ADDR, 8'h40, 8'h52);
    sfr_write(SUPPLY_MON_CTRL_ADDR, 8'h88);
    sfr_write(RESET_CAUSE_ADDR, 8'h02);
    pulse(1);
    await(3, 1'b1, 3);
    // Core supply dips below trip and recovers.
    @(posedge clk);
    sup_ok <= 1'b0;
    await(0, 1'b1, 8);
    check(16'({reset_pin_oe_n, reset_pin_out}), 16'h0000);
    @(posedge clk);
    sup_ok <= 1'b1;
    watch(0, 1'b0, 19, n);
    check(16'(n < 12), 16'h0001);
    sfr_read(RESET_CAUSE_ADDR, 8'h02, 8'h02);
    sfr_read(SUPPLY_MON_CTRL_ADDR, 8'h80, 8'h80);
    // The same dip in sleep must not reset.
    @(posedge clk);
    sleep_mode <= 1'b1;
    sup_ok     <= 1'b0;
    watch(0, 1'b1, 12, n);
    check(16'(n > 12), 16'h0001);
    sfr_read(SUPPLY_MON_CTRL_ADDR, 8'h00, 8'h40);
    // Let the trip comparator settle above the threshold before waking, or the wake itself trips.
    sup_ok     <= 1'b1;
    repeat (4) @(posedge clk);
    sleep_mode <= 1'b0;
    sfr_read(SUPPLY_MON_CTRL_ADDR, 8'h80, 8'h80);
    sup_warn_ok <= 1'b0;
    await(1, 1'b1, 8);
    sfr_read(SUPPLY_MON_CTRL_ADDR, 8'h00, 8'h20);
    sup_warn_ok <= 1'b1;
    // Battery warning with its enable randomly on, then the opposite.
    r = $random(seed);
    for (int i = 0; i < 2; i++) begin
      sfr_write(SUPPLY_MON_CTRL_ADDR, {5'h11, r[0] ^ i[0], 2'h0});
      bat_warn_ok <= 1'b0;
      watch(2, 1'b1, 8, n);
      check(16'(n <= 8), 16'(r[0] ^ i[0]));
      @(posedge clk);
      bat_warn_ok <= 1'b1;
      repeat (4) @(posedge clk);
    end
    sfr_write(POWER_UNIT_MODE_ADDR, 8'h20);
    // The monitor output follows the disable bit one clock after the write lands.
    repeat (2) @(negedge clk);
    check(16'(battery_monitor_on), 16'h0000);
    pulse(0);
    await(0, 1'b1, 8);
    watch(0, 1'b0, 100, n);
    check(16'(n >= DLY[2]), 16'h0001);
    check(16'(battery_monitor_on), 16'h0001);
    finish_test();
  end
endmodule
